//--- dacli_consts.svh
// Offsets, fields, reset values and timing counts of the DAC latch controller
`ifndef DACLI_CONSTS_SVH
`define DACLI_CONSTS_SVH

`define DACLI_OFF_CTRL          5'h00
`define DACLI_OFF_DATA          5'h04
`define DACLI_OFF_CLEAR         5'h08
`define DACLI_OFF_STATUS        5'h0c
`define DACLI_OFF_LAST          5'h10

`define DACLI_CTRL_SERIAL_BIT   0
`define DACLI_CLEAR_GO_BIT      0
`define DACLI_STAT_BUSY_BIT     0
`define DACLI_STAT_FULL_BIT     1
`define DACLI_STAT_EMPTY_BIT    2
`define DACLI_STAT_CLRPEND_BIT  3
`define DACLI_DATA_WORD_BITS    16

`define DACLI_CTRL_RESET        1'b0
`define DACLI_LAST_RESET        16'h0000

`define DACLI_RESP_OKAY         2'b00
`define DACLI_RESP_SLVERR       2'b10

`define DACLI_CLK_MHZ           40
`define DACLI_T_STROBE_HALF_NS  50
`define DACLI_T_ENABLE_GAP_NS   20
`define DACLI_HALF_CYC ((`DACLI_T_STROBE_HALF_NS * `DACLI_CLK_MHZ + 999) / 1000)
`define DACLI_GAP_CYC  ((`DACLI_T_ENABLE_GAP_NS * `DACLI_CLK_MHZ + 999) / 1000)

`endif

//--- dacli_pkg.sv
// Types of the DAC latch controller
package dacli_pkg;
  typedef enum logic [2:0] {
    DACLI_IDLE    = 3'b000,
    DACLI_SETUP   = 3'b001,
    DACLI_STRB_LO = 3'b010,
    DACLI_STRB_HI = 3'b011,
    DACLI_CLR     = 3'b100
  } dacli_state_t;

  typedef enum logic [1:0] {
    DACLI_TGT_LOW  = 2'b00,
    DACLI_TGT_HIGH = 2'b01,
    DACLI_TGT_SER  = 2'b10,
    DACLI_TGT_XFER = 2'b11
  } dacli_tgt_t;
endpackage

//--- dacli_fifo2.sv
// Small valid/ready buffer in the word path
`timescale 1ns/10ps
module dacli_fifo2 #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 2
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [PW-1:0]    next_wr_ptr;
  logic [PW-1:0]    next_rd_ptr;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  function automatic logic [PW-1:0] inc(input logic [PW-1:0] p);
    inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready  = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_comb begin
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = push ? inc(wr_ptr) : wr_ptr;
    next_rd_ptr = pop ? inc(rd_ptr) : rd_ptr;
    next_count  = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  property p_full_refuses;
    @(posedge aclk) disable iff (!aresetn)
      (count == CW'(DEPTH)) && !out_ready |=> (count == CW'(DEPTH)) && !in_ready;
  endproperty
  a_full_refuses: assert property (p_full_refuses) else $error("fifo lost full state");

  property p_pop_order;
    @(posedge aclk) disable iff (!aresetn)
      pop |=> (rd_ptr == inc($past(rd_ptr)));
  endproperty
  a_pop_order: assert property (p_pop_order) else $error("fifo read pointer skipped");
endmodule

//--- dacli_ctrl.sv
// AXI4-Lite driven controller for the pins of a latched 16-bit DAC
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "dacli_consts.svh"
// Function
// - All DAC controls are active low
// - Serial data on lowest line, MSB first
// - One bit shifted per write strobe pulse
// - Latch strobing no faster than 10 MHz
// - At least 20 ns between successive-enable strobes
// - Serial shifting no faster than 10 MHz
// - 4-bit pulse counter carry strobes transfer
module dacli_ctrl
  import dacli_pkg::*;
#(
  parameter int AW = 5
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output logic               chip_select_n,
  output logic               write_strobe_n,
  output logic               low_byte_enable_n,
  output logic               high_byte_enable_n,
  output logic               converter_latch_enable_n,
  output logic               latch_clear_n,
  output logic               data_lsb_serial_in,
  output logic [6:0]         data_upper
);
  localparam int TICK_CYC = (`DACLI_HALF_CYC > `DACLI_GAP_CYC) ? `DACLI_HALF_CYC
                                                             : `DACLI_GAP_CYC;

  // Register slave state
  logic          aw_held, next_aw_held;
  logic [AW-1:0] aw_addr, next_aw_addr;
  logic          w_held, next_w_held;
  logic [31:0]   w_data, next_w_data;
  logic [3:0]    w_strb, next_w_strb;
  logic          bvalid, next_bvalid;
  logic [1:0]    bresp, next_bresp;
  logic          ctrl_serial, next_ctrl_serial;
  logic          clear_req, next_clear_req;
  logic          rvalid, next_rvalid;
  logic [31:0]   rdata, next_rdata;
  logic [1:0]    rresp, next_rresp;
  logic          push_valid;
  logic          push_ready;
  logic          clear_take;

  // Pin sequencer state
  dacli_state_t  state, next_state;
  dacli_tgt_t    tgt, next_tgt;
  logic [3:0]    tick_cnt, next_tick_cnt;
  logic          tick;
  logic [15:0]   cmd_word, next_cmd_word;
  logic [15:0]   shift, next_shift;
  logic [15:0]   last_word, next_last_word;
  logic          serial_cmd, next_serial_cmd;
  logic [3:0]    bit_cnt, next_bit_cnt;
  logic [5:0]    pins, next_pins;
  logic [7:0]    dat, next_dat;
  logic          pop_valid;
  logic          pop_ready;
  logic [16:0]   pop_data;

  dacli_fifo2 #(.WIDTH(17), .DEPTH(2)) i_dacli_fifo2 (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   ({ctrl_serial, w_data[15:0]}),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_data)
  );

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;
  // A data write waits here while the buffer is full
  assign push_valid = aw_held && w_held && !bvalid && (aw_addr == `DACLI_OFF_DATA);

  always_comb begin
    next_aw_held     = aw_held;
    next_aw_addr     = aw_addr;
    next_w_held      = w_held;
    next_w_data      = w_data;
    next_w_strb      = w_strb;
    next_bvalid      = bvalid;
    next_bresp       = bresp;
    next_ctrl_serial = ctrl_serial;
    next_clear_req   = clear_req && !clear_take;
    if (s_axi_awvalid && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_held && w_held && !bvalid) begin
      next_bresp = `DACLI_RESP_OKAY;
      case (aw_addr)
        `DACLI_OFF_CTRL: begin
          if (w_strb[0]) begin
            next_ctrl_serial = w_data[`DACLI_CTRL_SERIAL_BIT];
          end
        end
        `DACLI_OFF_CLEAR: begin
          // Set wins over the sequencer taking the request
          if (w_strb[0] && w_data[`DACLI_CLEAR_GO_BIT]) begin
            next_clear_req = 1'b1;
          end
        end
        `DACLI_OFF_DATA, `DACLI_OFF_STATUS, `DACLI_OFF_LAST: begin
        end
        default: begin
          next_bresp = `DACLI_RESP_SLVERR;
        end
      endcase
      if (aw_addr != `DACLI_OFF_DATA || push_ready) begin
        next_aw_held = 1'b0;
        next_w_held  = 1'b0;
        next_bvalid  = 1'b1;
      end
    end
  end

  always_comb begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rdata  = 32'h0000_0000;
      next_rresp  = `DACLI_RESP_OKAY;
      case (s_axi_araddr)
        `DACLI_OFF_CTRL: next_rdata[`DACLI_CTRL_SERIAL_BIT] = ctrl_serial;
        `DACLI_OFF_DATA, `DACLI_OFF_CLEAR: begin
        end
        `DACLI_OFF_STATUS: begin
          next_rdata[`DACLI_STAT_BUSY_BIT]    = (state != DACLI_IDLE);
          next_rdata[`DACLI_STAT_FULL_BIT]    = !push_ready;
          next_rdata[`DACLI_STAT_EMPTY_BIT]   = !pop_valid;
          next_rdata[`DACLI_STAT_CLRPEND_BIT] = clear_req;
        end
        `DACLI_OFF_LAST: next_rdata[15:0] = last_word;
        default: next_rresp = `DACLI_RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held     <= 1'b0;
      aw_addr     <= '0;
      w_held      <= 1'b0;
      w_data      <= 32'h0000_0000;
      w_strb      <= 4'h0;
      bvalid      <= 1'b0;
      bresp       <= `DACLI_RESP_OKAY;
      ctrl_serial <= `DACLI_CTRL_RESET;
      clear_req   <= 1'b0;
      rvalid      <= 1'b0;
      rdata       <= 32'h0000_0000;
      rresp       <= `DACLI_RESP_OKAY;
    end else begin
      aw_held     <= next_aw_held;
      aw_addr     <= next_aw_addr;
      w_held      <= next_w_held;
      w_data      <= next_w_data;
      w_strb      <= next_w_strb;
      bvalid      <= next_bvalid;
      bresp       <= next_bresp;
      ctrl_serial <= next_ctrl_serial;
      clear_req   <= next_clear_req;
      rvalid      <= next_rvalid;
      rdata       <= next_rdata;
      rresp       <= next_rresp;
    end
  end

  // Enables and data for one target: {lo_n, hi_n, xf_n} plus the bus byte
  function automatic logic [10:0] drive(input dacli_tgt_t t, input logic [15:0] w,
                                        input logic [15:0] s);
    case (t)
      DACLI_TGT_LOW:  drive = {3'b011, w[7:0]};
      DACLI_TGT_HIGH: drive = {3'b101, w[15:8]};
      DACLI_TGT_SER:  drive = {3'b001, 7'h00, s[15]};
      DACLI_TGT_XFER: drive = {3'b110, 8'h00};
      default:        drive = {3'b111, 8'h00};
    endcase
  endfunction

  assign tick      = (tick_cnt == 4'(TICK_CYC - 1));
  assign pop_ready = (state == DACLI_IDLE) && tick && !clear_req;
  assign clear_take = (state == DACLI_IDLE) && tick && clear_req;
  // pins = {cs_n, wr_n, lo_n, hi_n, xf_n, clr_n}
  assign chip_select_n            = pins[5];
  assign write_strobe_n           = pins[4];
  assign low_byte_enable_n        = pins[3];
  assign high_byte_enable_n       = pins[2];
  assign converter_latch_enable_n = pins[1];
  assign latch_clear_n            = pins[0];
  assign data_lsb_serial_in       = dat[0];
  assign data_upper               = dat[7:1];

  always_comb begin
    logic [10:0] d;
    d               = 11'h000;
    next_state      = state;
    next_tgt        = tgt;
    next_tick_cnt   = tick ? 4'h0 : tick_cnt + 4'h1;
    next_cmd_word   = cmd_word;
    next_shift      = shift;
    next_last_word  = last_word;
    next_serial_cmd = serial_cmd;
    next_bit_cnt    = bit_cnt;
    next_pins       = pins;
    next_dat        = dat;
    if (tick) begin
      case (state)
        DACLI_IDLE: begin
          if (clear_req) begin
            next_pins  = 6'b111110;
            next_state = DACLI_CLR;
          end else if (pop_valid) begin
            next_cmd_word   = pop_data[15:0];
            next_shift      = pop_data[15:0];
            next_serial_cmd = pop_data[16];
            next_tgt        = pop_data[16] ? DACLI_TGT_SER : DACLI_TGT_LOW;
            next_bit_cnt    = 4'h0;
            d               = drive(next_tgt, pop_data[15:0], pop_data[15:0]);
            next_pins       = {2'b01, d[10:8], 1'b1};
            next_dat        = d[7:0];
            next_state      = DACLI_SETUP;
          end
        end
        DACLI_SETUP: begin
          next_pins[4] = 1'b0;
          next_state   = DACLI_STRB_LO;
        end
        DACLI_STRB_LO: begin
          // Low for one tick, then high at least one tick
          next_pins[4] = 1'b1;
          next_state   = DACLI_STRB_HI;
        end
        DACLI_STRB_HI: begin
          case (tgt)
            DACLI_TGT_LOW:  next_tgt = DACLI_TGT_HIGH;
            DACLI_TGT_HIGH: next_tgt = DACLI_TGT_XFER;
            DACLI_TGT_SER: begin
              // Counter carry after sixteen pulses starts the transfer
              if (bit_cnt == 4'hf) begin
                next_tgt = DACLI_TGT_XFER;
              end
            end
            default: begin
            end
          endcase
          if (tgt == DACLI_TGT_XFER) begin
            next_last_word = cmd_word;
            next_pins      = 6'b111111;
            next_dat       = 8'h00;
            next_state     = DACLI_IDLE;
          end else if (tgt == DACLI_TGT_SER && bit_cnt != 4'hf) begin
            next_bit_cnt = bit_cnt + 4'h1;
            next_shift   = {shift[14:0], 1'b0};
            next_dat     = {7'h00, shift[14]};
            // Next bit settles a full tick before the strobe falls
            next_state   = DACLI_SETUP;
          end else begin
            // Enables swap only after a full tick of strobe high
            d            = drive(next_tgt, cmd_word, shift);
            next_pins    = {2'b01, d[10:8], 1'b1};
            next_dat     = d[7:0];
            next_state   = DACLI_SETUP;
          end
        end
        DACLI_CLR: begin
          next_pins  = 6'b111111;
          next_state = DACLI_IDLE;
        end
        default: begin
          next_pins  = 6'b111111;
          next_state = DACLI_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state      <= DACLI_IDLE;
      tgt        <= DACLI_TGT_LOW;
      tick_cnt   <= 4'h0;
      cmd_word   <= 16'h0000;
      shift      <= 16'h0000;
      last_word  <= `DACLI_LAST_RESET;
      serial_cmd <= 1'b0;
      bit_cnt    <= 4'h0;
      pins       <= 6'b111111;
      dat        <= 8'h00;
    end else begin
      state      <= next_state;
      tgt        <= next_tgt;
      tick_cnt   <= next_tick_cnt;
      cmd_word   <= next_cmd_word;
      shift      <= next_shift;
      last_word  <= next_last_word;
      serial_cmd <= next_serial_cmd;
      bit_cnt    <= next_bit_cnt;
      pins       <= next_pins;
      dat        <= next_dat;
    end
  end

  // Helper: falling strobes seen while both byte enables are low
  logic [4:0] ser_pulses;
  always_ff @(posedge aclk) begin
    if (!aresetn || state == DACLI_IDLE) begin
      ser_pulses <= 5'h00;
    end else if ($fell(write_strobe_n) && !low_byte_enable_n && !high_byte_enable_n) begin
      ser_pulses <= ser_pulses + 5'h01;
    end
  end

  property p_strobe_needs_select;
    @(posedge aclk) disable iff (!aresetn) !write_strobe_n |-> !chip_select_n;
  endproperty
  a_strobe_needs_select: assert property (p_strobe_needs_select)
    else $error("write strobe low without chip select");

  property p_clear_alone;
    @(posedge aclk) disable iff (!aresetn)
      $fell(latch_clear_n) |-> (!latch_clear_n && write_strobe_n && chip_select_n) [*2];
  endproperty
  a_clear_alone: assert property (p_clear_alone)
    else $error("clear pulse too short or overlapping a strobe");

  property p_serial_msb_first;
    @(posedge aclk) disable iff (!aresetn)
      !write_strobe_n && !low_byte_enable_n && !high_byte_enable_n
        |-> data_lsb_serial_in == cmd_word[4'hf - bit_cnt];
  endproperty
  a_serial_msb_first: assert property (p_serial_msb_first)
    else $error("serial bit out of order");

  property p_sixteen_pulses;
    @(posedge aclk) disable iff (!aresetn)
      $fell(converter_latch_enable_n) && serial_cmd |-> ser_pulses == 5'h10;
  endproperty
  a_sixteen_pulses: assert property (p_sixteen_pulses)
    else $error("serial transfer not after sixteen pulses");

  property p_transfer_bounded;
    @(posedge aclk) disable iff (!aresetn)
      ser_pulses == 5'h10 && $rose(write_strobe_n) |-> ##[1:4] !converter_latch_enable_n;
  endproperty
  a_transfer_bounded: assert property (p_transfer_bounded)
    else $error("carry did not strobe the transfer");

  property p_strobe_low_width;
    @(posedge aclk) disable iff (!aresetn) $fell(write_strobe_n) |-> !write_strobe_n [*2];
  endproperty
  a_strobe_low_width: assert property (p_strobe_low_width)
    else $error("write strobe low shorter than half period");

  property p_strobe_high_width;
    @(posedge aclk) disable iff (!aresetn) $rose(write_strobe_n) |-> write_strobe_n [*2];
  endproperty
  a_strobe_high_width: assert property (p_strobe_high_width)
    else $error("write strobe high shorter than half period");

  property p_enable_gap;
    @(posedge aclk) disable iff (!aresetn)
      $changed({low_byte_enable_n, high_byte_enable_n, converter_latch_enable_n})
        |-> write_strobe_n && $past(write_strobe_n);
  endproperty
  a_enable_gap: assert property (p_enable_gap)
    else $error("enable changed too close to a strobe");

  c_parallel: cover property (@(posedge aclk) disable iff (!aresetn)
    $fell(converter_latch_enable_n) && !serial_cmd);
  c_serial: cover property (@(posedge aclk) disable iff (!aresetn)
    $fell(converter_latch_enable_n) && serial_cmd);
  c_clear: cover property (@(posedge aclk) disable iff (!aresetn) $fell(latch_clear_n));
  c_full: cover property (@(posedge aclk) disable iff (!aresetn) push_valid && !push_ready);
endmodule

//--- dacli_dac_model.sv
// Behavioural model of the latched 16-bit DAC behind the controller pins
`timescale 1ns/10ps
module dacli_dac_model (
  input  wire logic       chip_select_n,
  input  wire logic       write_strobe_n,
  input  wire logic       low_byte_enable_n,
  input  wire logic       high_byte_enable_n,
  input  wire logic       converter_latch_enable_n,
  input  wire logic       latch_clear_n,
  input  wire logic       data_lsb_serial_in,
  input  wire logic [6:0] data_upper,
  output logic [7:0]      low_latch,
  output logic [7:0]      high_latch,
  output logic [15:0]     dac_word,
  output int              xfer_cnt,
  output int              shift_cnt,
  output int              viol_cnt
);
  logic [7:0] bus_byte;
  logic       ser_mode;
  logic       wr_prev;
  realtime    t_wr;
  realtime    t_en;
  assign bus_byte = {data_upper, data_lsb_serial_in};
  assign ser_mode = !low_byte_enable_n && !high_byte_enable_n;
  initial begin
    // Odd start pattern so a missed load shows up
    low_latch = 8'h55;
    high_latch = 8'h55;
    dac_word = 16'h5555;
    xfer_cnt = 0;
    shift_cnt = 0;
    viol_cnt = 0;
    wr_prev = 1'b1;
    t_wr = -1000.0;
    t_en = -1000.0;
  end
  always @(low_byte_enable_n or high_byte_enable_n or converter_latch_enable_n) begin
    t_en = $realtime;
  end
  always @(write_strobe_n or latch_clear_n or chip_select_n or bus_byte or low_byte_enable_n
           or high_byte_enable_n or converter_latch_enable_n) begin
    if (wr_prev && !write_strobe_n) begin
      if ($realtime - t_wr < 100.0) viol_cnt++;
      if ($realtime - t_en < 20.0) viol_cnt++;
      if (chip_select_n) viol_cnt++;
      t_wr = $realtime;
    end
    if (!latch_clear_n) begin
      low_latch = 8'h00;
      high_latch = 8'h00;
      dac_word = 16'h0000;
    end else if (!chip_select_n && !write_strobe_n) begin
      if (ser_mode && wr_prev) begin
        {high_latch, low_latch} = {high_latch[6:0], low_latch, data_lsb_serial_in};
        shift_cnt++;
      end
      if (!ser_mode && !low_byte_enable_n) low_latch = bus_byte;
      if (!ser_mode && !high_byte_enable_n) high_latch = bus_byte;
      if (!converter_latch_enable_n) begin
        if (wr_prev) xfer_cnt++;
        dac_word = {high_latch, low_latch};
      end
    end
    wr_prev = write_strobe_n;
  end
endmodule

//--- test_dacli_ctrl.sv
// Self-checking bench for the DAC latch controller
`timescale 1ns/10ps
`include "dacli_consts.svh"
module test_dacli_ctrl;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  logic        cs_n, wr_n, lo_n, hi_n, xf_n, clr_n, d0;
  logic [6:0]  dup;
  logic [7:0]  low_l, high_l;
  logic [15:0] dac;
  logic [15:0] words [4] = '{16'h0001, 16'h8000, 16'h00ff, 16'hff00};
  int          xfers, shifts, viols, mismatches, tests_run, x0;

  dacli_ctrl #(.AW(5)) i_dacli_ctrl (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .chip_select_n(cs_n), .write_strobe_n(wr_n), .low_byte_enable_n(lo_n),
    .high_byte_enable_n(hi_n), .converter_latch_enable_n(xf_n), .latch_clear_n(clr_n),
    .data_lsb_serial_in(d0), .data_upper(dup));
  dacli_dac_model i_dacli_dac_model (.chip_select_n(cs_n), .write_strobe_n(wr_n),
    .low_byte_enable_n(lo_n), .high_byte_enable_n(hi_n), .converter_latch_enable_n(xf_n),
    .latch_clear_n(clr_n), .data_lsb_serial_in(d0), .data_upper(dup), .low_latch(low_l),
    .high_latch(high_l), .dac_word(dac), .xfer_cnt(xfers), .shift_cnt(shifts),
    .viol_cnt(viols));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Handshakes are judged at the falling edge, where every value is settled
  task automatic wr32(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_t, w_t, b_t;
    b_t = 1'b0;
    // An edge between calls, so no signal is driven twice in one step
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_t) begin
      @(negedge aclk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid && bready;
      r = bresp;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) bready <= 1'b0;
    end
  endtask

  task automatic rd32(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_t, r_t;
    r_t = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_t) begin
      @(negedge aclk);
      ar_t = arvalid && arready;
      r_t = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_t) arvalid <= 1'b0;
      if (r_t) rready <= 1'b0;
    end
  endtask

  task automatic wait_idle;
    rd = 32'h0;
    while (rd !== 32'h4) rd32(`DACLI_OFF_STATUS, rd, rsp);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #(25.0 * 20000);
    mismatches++;
    stop_test;
  end

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 5'h00;
    araddr = 5'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd32(`DACLI_OFF_CTRL, rd, rsp);
    chk("ctrl reset", rd, 32'h0);
    rd32(`DACLI_OFF_LAST, rd, rsp);
    chk("last reset", rd, 32'h0);
    rd32(`DACLI_OFF_STATUS, rd, rsp);
    chk("status reset", rd, 32'h4);
    chk("pins idle", {cs_n, wr_n, lo_n, hi_n, xf_n, clr_n}, 32'h3f);
    $display("test reset done");
    x0 = xfers;
    wr32(`DACLI_OFF_DATA, 32'h0000a5c3, rsp);
    wait_idle;
    chk("dac parallel", dac, 32'ha5c3);
    chk("byte latches", {high_l, low_l}, 32'ha5c3);
    chk("one transfer", 32'(xfers - x0), 32'h1);
    rd32(`DACLI_OFF_LAST, rd, rsp);
    chk("last word", rd, 32'ha5c3);
    $display("test parallel done");
    // Fourth word has to wait for a free slot
    x0 = xfers;
    foreach (words[i]) wr32(`DACLI_OFF_DATA, {16'h0, words[i]}, rsp);
    rd32(`DACLI_OFF_STATUS, rd, rsp);
    chk("buffer full", rd[`DACLI_STAT_FULL_BIT], 32'h1);
    wait_idle;
    chk("dac burst", dac, 32'hff00);
    chk("burst transfers", 32'(xfers - x0), 32'h4);
    $display("test buffer done");
    wr32(`DACLI_OFF_CTRL, 32'h1, rsp);
    rd32(`DACLI_OFF_CTRL, rd, rsp);
    chk("ctrl serial", rd, 32'h1);
    x0 = shifts;
    wr32(`DACLI_OFF_DATA, 32'h00009c35, rsp);
    wait_idle;
    chk("dac serial", dac, 32'h9c35);
    chk("serial bits", 32'(shifts - x0), 32'h10);
    wr32(`DACLI_OFF_CTRL, 32'h0, rsp);
    $display("test serial done");
    wr32(`DACLI_OFF_CLEAR, 32'h1, rsp);
    wait_idle;
    chk("dac cleared", dac, 32'h0);
    chk("latches cleared", {high_l, low_l}, 32'h0);
    $display("test clear done");
    wr32(5'h14, 32'h1, rsp);
    chk("bad write resp", rsp, `DACLI_RESP_SLVERR);
    rd32(5'h14, rd, rsp);
    chk("bad read resp", rsp, `DACLI_RESP_SLVERR);
    chk("bad read data", rd, 32'h0);
    wr32(`DACLI_OFF_STATUS, 32'hf, rsp);
    chk("ro write resp", rsp, `DACLI_RESP_OKAY);
    chk("pin timing", 32'(viols), 32'h0);
    $display("test errors done");
    stop_test;
  end
endmodule
